// file: hdl/vic_vectored_irq_ctrl.sv
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module vic_vectored_irq_ctrl (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_fast_irq_input,
	input wire logic [3:0] i_system_irq_source,
	input wire logic [31:2] i_peripheral_source,
	output logic o_normal_request_n,
	output logic o_fast_request_n
);
	logic ph_wr_q;
	logic ph_rd_q;
	logic [8:0] addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdata_d;
	logic take;
	logic rd_cap;
	logic vec_rd;
	logic fvr_rd;
	logic eos_wr;
	logic [4:0] idx;
	vic_pkg::vic_mode_t mode_q [vic_pkg::NUM_SRC];
	logic [31:0] svr_q [vic_pkg::NUM_SRC];
	logic [31:0] mask_q;
	logic [31:0] ff_q;
	logic [31:0] act_v;
	logic [31:0] edge_v;
	logic [31:0] latch_v;
	logic [31:0] edge_mode_v;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [31:0] cand;
	logic best_found;
	vic_pkg::vic_num_t best_num;
	vic_pkg::vic_prio_t best_lvl;
	logic want_irq;
	logic want_fast;
	logic [3:0] depth_q;
	vic_pkg::vic_num_t cur_num_q;
	vic_pkg::vic_prio_t cur_lvl_q;
	vic_pkg::vic_num_t stk_num_q [vic_pkg::STACK_DEPTH];
	vic_pkg::vic_prio_t stk_lvl_q [vic_pkg::STACK_DEPTH];
	vic_pkg::vic_prio_t top_lvl;
	vic_pkg::vic_num_t top_num;
	logic irq_n_q;
	logic fast_n_q;

	// one address phase at a time; reads get one wait state
	assign take = i_hsel & i_htrans[1] & i_hready;
	assign rd_cap = ph_rd_q;
	assign idx = addr_q[6:2];
	assign vec_rd = rd_cap && (addr_q == vic_pkg::OFS_VECTOR);
	assign fvr_rd = rd_cap && (addr_q == vic_pkg::OFS_FAST_VECTOR);
	assign eos_wr = ph_wr_q && (addr_q == vic_pkg::OFS_EOS);
	assign o_hreadyout = ~ph_rd_q;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_q;

	// bus phase tracking; hsize ignored, word access only
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			addr_q <= 9'h000;
		end else begin
			ph_wr_q <= take & i_hwrite;
			ph_rd_q <= take & ~i_hwrite;
			if (take) begin
				addr_q <= i_haddr[8:0];
			end
		end
	end

	// read mux; the wait state lets a preceding write land first
	always_comb begin
		rdata_d = 32'h0;
		if (addr_q[8:7] == vic_pkg::BANK_MODE) begin
			rdata_d = {25'h0, mode_q[idx]};
		end else if (addr_q[8:7] == vic_pkg::BANK_VEC) begin
			rdata_d = svr_q[idx];
		end else begin
			case (addr_q)
				vic_pkg::OFS_VECTOR: begin
					// handler of the source chosen now
					rdata_d = best_found ? svr_q[best_num] : vic_pkg::NO_VECTOR;
				end
				vic_pkg::OFS_FAST_VECTOR: rdata_d = svr_q[0];
				vic_pkg::OFS_CUR_NUM: rdata_d = {27'h0, cur_num_q};
				vic_pkg::OFS_PENDING: rdata_d = act_v;
				vic_pkg::OFS_MASK: rdata_d = mask_q;
				vic_pkg::OFS_CORE: rdata_d = {30'h0, ~fast_n_q, ~irq_n_q};
				vic_pkg::OFS_FF_STATUS: rdata_d = ff_q;
				default: rdata_d = 32'h0;
			endcase
		end
	end

	// read data register, loaded at the end of the wait state
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hrdata_q <= 32'h0;
		end else if (rd_cap) begin
			hrdata_q <= rdata_d;
		end
	end

	// mode and vector tables
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
				mode_q[i] <= vic_pkg::MODE_RST;
				svr_q[i] <= vic_pkg::VEC_RST;
			end
		end else if (ph_wr_q && addr_q[8:7] == vic_pkg::BANK_MODE) begin
			// bits 4:3 are reserved and stay zero
			mode_q[idx] <= {i_hwdata[6:5], 2'b00, i_hwdata[2:0]};
		end else if (ph_wr_q && addr_q[8:7] == vic_pkg::BANK_VEC) begin
			svr_q[idx] <= i_hwdata;
		end
	end

	// mask: enable and disable commands act in one write
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mask_q <= vic_pkg::MASK_RST;
		end else if (ph_wr_q && addr_q == vic_pkg::OFS_ENABLE) begin
			mask_q <= mask_q | i_hwdata;
		end else if (ph_wr_q && addr_q == vic_pkg::OFS_DISABLE) begin
			mask_q <= mask_q & ~i_hwdata;
		end
	end

	// fast forcing redirect set
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ff_q <= vic_pkg::FF_RST;
		end else if (ph_wr_q && addr_q == vic_pkg::OFS_FF_ENABLE) begin
			ff_q <= ff_q | (i_hwdata & vic_pkg::NORMAL_SRC_MASK);
		end else if (ph_wr_q && addr_q == vic_pkg::OFS_FF_DISABLE) begin
			ff_q <= ff_q & ~i_hwdata;
		end
	end

	// command and automatic clears, gated to edge sources
	always_comb begin
		set_v = 32'h0;
		clr_v = 32'h0;
		if (ph_wr_q && addr_q == vic_pkg::OFS_SET) begin
			set_v = i_hwdata & edge_mode_v;
		end
		if (ph_wr_q && addr_q == vic_pkg::OFS_CLEAR) begin
			clr_v = i_hwdata & edge_mode_v;
		end
		if (vec_rd && best_found && !ff_q[best_num]) begin
			clr_v = clr_v | (32'h1 << best_num);
		end
		if (fvr_rd) begin
			clr_v = clr_v | vic_pkg::FAST_SRC_MASK;
		end
	end

	// per-source input stage
	for (genvar g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_src
		logic raw;
		logic line;
		logic prev_q;
		logic latch_q;
		logic pol;
		logic edge_mode;
		logic edge_evt;
		if (g == 0) begin : g_fast
			assign raw = i_fast_irq_input;
		end else if (g == 1) begin : g_system
			assign raw = |i_system_irq_source;
		end else begin : g_per
			assign raw = i_peripheral_source[g];
		end
		if (vic_pkg::EXT_SRC_MASK[g]) begin : g_ext
			logic s1_q;
			logic s2_q;
			// pins are asynchronous; first stage feeds only the second
			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
				end else begin
					s1_q <= raw;
					s2_q <= s1_q;
				end
			end
			assign line = s2_q;
			assign pol = mode_q[g][vic_pkg::TRIG_POL_BIT];
		end else begin : g_int
			assign line = raw;
			assign pol = 1'b1;
		end
		assign edge_mode = mode_q[g][vic_pkg::TRIG_EDGE_BIT];
		assign edge_evt = pol ? (line & ~prev_q) : (~line & prev_q);
		// latch: a new edge in the clear cycle wins over the clear
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				prev_q <= 1'b0;
				latch_q <= 1'b0;
			end else begin
				prev_q <= line;
				latch_q <= edge_mode &
					((latch_q & ~clr_v[g]) | edge_evt | set_v[g]);
			end
		end
		assign act_v[g] = edge_mode ? latch_q : (line == pol);
		assign edge_v[g] = edge_evt;
		assign latch_v[g] = latch_q;
		assign edge_mode_v[g] = edge_mode;
	end

	// candidates exclude source 0, masked and fast-forced sources
	assign cand = act_v & mask_q & ~ff_q & vic_pkg::NORMAL_SRC_MASK;

	// highest priority wins, strict compare keeps lowest number on ties
	always_comb begin
		best_found = 1'b0;
		best_num = 5'h00;
		best_lvl = 3'h0;
		for (int i = 1; i < vic_pkg::NUM_SRC; i++) begin
			if (cand[i] && (!best_found ||
				mode_q[i][vic_pkg::PRIO_LSB +: vic_pkg::PRIO_W] > best_lvl)) begin
				best_found = 1'b1;
				best_num = 5'(i);
				best_lvl = mode_q[i][vic_pkg::PRIO_LSB +: vic_pkg::PRIO_W];
			end
		end
	end

	// idle: any candidate; in service: only above the current level
	assign want_irq = best_found &&
		(depth_q == vic_pkg::DEPTH_EMPTY || best_lvl > cur_lvl_q);
	assign want_fast = |(act_v & mask_q & (ff_q | vic_pkg::FAST_SRC_MASK));
	assign top_lvl = stk_lvl_q[depth_q[2:0] - 3'h1];
	assign top_num = stk_num_q[depth_q[2:0] - 3'h1];

	// nesting stack; a read at full depth returns a vector but no push
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			depth_q <= vic_pkg::DEPTH_EMPTY;
			cur_num_q <= 5'h00;
			cur_lvl_q <= 3'h0;
			for (int i = 0; i < vic_pkg::STACK_DEPTH; i++) begin
				stk_num_q[i] <= 5'h00;
				stk_lvl_q[i] <= 3'h0;
			end
		end else if (vec_rd && best_found && depth_q != vic_pkg::DEPTH_FULL) begin
			stk_num_q[depth_q[2:0]] <= cur_num_q;
			stk_lvl_q[depth_q[2:0]] <= cur_lvl_q;
			depth_q <= depth_q + 4'h1;
			cur_num_q <= best_num;
			cur_lvl_q <= best_lvl;
		end else if (eos_wr && depth_q != vic_pkg::DEPTH_EMPTY) begin
			depth_q <= depth_q - 4'h1;
			cur_num_q <= top_num;
			cur_lvl_q <= top_lvl;
		end
	end

	// request lines, registered; a read drops irq via new level
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_n_q <= 1'b1;
			fast_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~want_irq;
			fast_n_q <= ~want_fast;
		end
	end
	assign o_normal_request_n = irq_n_q;
	assign o_fast_request_n = fast_n_q;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_vec_take;
		vec_rd && best_found && depth_q != vic_pkg::DEPTH_FULL;
	endsequence
	sequence s_eos_pop;
		eos_wr && depth_q != vic_pkg::DEPTH_EMPTY;
	endsequence

	property p_vec_level;
		s_vec_take |=> cur_lvl_q == $past(best_lvl) &&
			cur_num_q == $past(best_num);
	endproperty
	a_vec_level: assert property (p_vec_level)
		else $error("level not taken from chosen source");

	property p_vec_push;
		s_vec_take |=> depth_q == $past(depth_q) + 4'h1;
	endproperty
	a_vec_push: assert property (p_vec_push)
		else $error("vector read did not push");

	property p_eos_pop;
		s_eos_pop |=> depth_q == $past(depth_q) - 4'h1 &&
			cur_lvl_q == $past(top_lvl);
	endproperty
	a_eos_pop: assert property (p_eos_pop)
		else $error("end of service did not restore level");

	property p_irq_track;
		1'b1 |=> o_normal_request_n == !$past(want_irq);
	endproperty
	a_irq_track: assert property (p_irq_track)
		else $error("normal request out of step");

	property p_cand;
		best_found |-> mask_q[best_num] && !ff_q[best_num] &&
			best_num != 5'h00;
	endproperty
	a_cand: assert property (p_cand)
		else $error("masked or forced source chosen");

	property p_fvr_clear;
		fvr_rd && !edge_v[0] && set_v[0] == 1'b0 |=> !latch_v[0];
	endproperty
	a_fvr_clear: assert property (p_fvr_clear)
		else $error("fast vector read left source 0 latched");

	property p_enable;
		ph_wr_q && addr_q == vic_pkg::OFS_ENABLE |=>
			(mask_q & $past(i_hwdata)) == $past(i_hwdata);
	endproperty
	a_enable: assert property (p_enable)
		else $error("enable write lost");

	property p_disable;
		ph_wr_q && addr_q == vic_pkg::OFS_DISABLE |=>
			(mask_q & $past(i_hwdata)) == 32'h0;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disable write lost");

	property p_read_wait;
		take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read wait state wrong");

endmodule // vic_vectored_irq_ctrl

// file: pkg/vic_pkg.sv
package vic_pkg;
	// source count, nesting depth, system line fan-in
	localparam int NUM_SRC = 32;
	localparam int SYS_LINES = 4;
	localparam int STACK_DEPTH = 8;
	localparam logic [3:0] DEPTH_FULL = 4'h8;
	localparam logic [3:0] DEPTH_EMPTY = 4'h0;
	// sources wired to pins, the rest are internal lines
	localparam logic [31:0] EXT_SRC_MASK = 32'he0000001;
	localparam logic [31:0] NORMAL_SRC_MASK = 32'hfffffffe;
	localparam logic [31:0] FAST_SRC_MASK = 32'h00000001;

	// byte offsets inside the 512-byte window
	localparam logic [8:0] OFS_MODE_BASE = 9'h000;
	localparam logic [8:0] OFS_VEC_BASE = 9'h080;
	localparam logic [8:0] OFS_VECTOR = 9'h100;
	localparam logic [8:0] OFS_FAST_VECTOR = 9'h104;
	localparam logic [8:0] OFS_CUR_NUM = 9'h108;
	localparam logic [8:0] OFS_PENDING = 9'h10c;
	localparam logic [8:0] OFS_MASK = 9'h110;
	localparam logic [8:0] OFS_CORE = 9'h114;
	localparam logic [8:0] OFS_ENABLE = 9'h120;
	localparam logic [8:0] OFS_DISABLE = 9'h124;
	localparam logic [8:0] OFS_CLEAR = 9'h128;
	localparam logic [8:0] OFS_SET = 9'h12c;
	localparam logic [8:0] OFS_EOS = 9'h130;
	localparam logic [8:0] OFS_FF_ENABLE = 9'h140;
	localparam logic [8:0] OFS_FF_DISABLE = 9'h144;
	localparam logic [8:0] OFS_FF_STATUS = 9'h148;
	localparam logic [1:0] BANK_MODE = 2'h0;
	localparam logic [1:0] BANK_VEC = 2'h1;

	// source mode field layout
	localparam int PRIO_LSB = 0;
	localparam int PRIO_W = 3;
	localparam int TRIG_EDGE_BIT = 5;
	localparam int TRIG_POL_BIT = 6;
	localparam int MODE_W = 7;

	// reset values
	localparam logic [6:0] MODE_RST = 7'h00;
	localparam logic [31:0] VEC_RST = 32'h0;
	localparam logic [31:0] MASK_RST = 32'h0;
	localparam logic [31:0] FF_RST = 32'h0;
	localparam logic [31:0] NO_VECTOR = 32'h0;

	typedef logic [6:0] vic_mode_t;
	typedef logic [2:0] vic_prio_t;
	typedef logic [4:0] vic_num_t;
endpackage

// file: test/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model (
	input wire logic i_clk,
	input wire logic i_hready,
	input wire logic [31:0] i_hrdata,
	output logic o_hsel,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata,
	output logic [31:0] o_rd_data,
	output logic [7:0] o_rd_cnt
);
	// bus idle at time zero, word size only
	initial begin
		o_hsel = 1'b0;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h5a5a5a5a;
		o_rd_data = 32'h0;
		o_rd_cnt = 8'h0;
	end

	// single word transfer, each phase held until hready is seen high
	task automatic xfer(input logic w, input logic [8:0] a,
		input logic [31:0] d);
		o_hsel <= 1'b1;
		o_haddr <= {23'h0, a};
		o_hwrite <= w;
		o_htrans <= 2'h2;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		o_hsel <= 1'b0;
		o_htrans <= 2'h0;
		o_hwdata <= d;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		// released data bus flips so a stale value never looks valid
		o_hwdata <= ~d;
		if (!w) begin
			o_rd_data <= i_hrdata;
			o_rd_cnt <= o_rd_cnt + 8'h1;
		end
	endtask

	// handler entry is a vector read, normal or fast
	task automatic enter_irq(input logic fast);
		xfer(1'b0, fast ? vic_pkg::OFS_FAST_VECTOR : vic_pkg::OFS_VECTOR,
			32'h0);
	endtask

	// handler exit is a write of end of service
	task automatic leave_irq;
		xfer(1'b1, vic_pkg::OFS_EOS, 32'h0);
	endtask
endmodule // vic_core_model

// file: test/vic_vectored_irq_ctrl_test.sv
`timescale 1ns/1ps
module vic_vectored_irq_ctrl_test;
	logic clk;
	logic arst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic fast_pin;
	logic [3:0] system_lines;
	logic [31:2] per_lines;
	logic normal_request_n;
	logic fast_request_n;
	logic [31:0] rd_data;
	logic [7:0] rd_cnt;
	logic [31:0] exp_q[$];
	logic [31:0] seed;
	logic [4:0] src_tab [7] = '{5'd5, 5'd7, 5'd9, 5'd11, 5'd0, 5'd31, 5'd1};
	logic [31:0] mode_tab [7] = '{32'h23, 32'h23, 32'h06, 32'h27, 32'h20,
		32'h22, 32'h01};
	int fail_count;
	int samples_checked;
	int n;

	vic_vectored_irq_ctrl dut (.i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .i_fast_irq_input(fast_pin),
		.i_system_irq_source(system_lines), .i_peripheral_source(per_lines),
		.o_normal_request_n(normal_request_n),
		.o_fast_request_n(fast_request_n));

	vic_core_model core (.i_clk(clk), .i_hready(hreadyout), .i_hrdata(hrdata),
		.o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
		.o_hsize(hsize), .o_hwdata(hwdata), .o_rd_data(rd_data),
		.o_rd_cnt(rd_cnt));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic [8:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		core.xfer(1'b0, a, 32'h0);
	endtask

	task automatic take(input logic fast, input logic [31:0] exp);
		exp_q.push_back(exp);
		core.enter_irq(fast);
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		core.xfer(1'b1, a, d);
	endtask

	// request lines looked at mid-cycle, where they have settled
	task automatic lines(input logic nr, input logic fr);
		@(negedge clk);
		check({31'h0, normal_request_n}, {31'h0, nr}, "normal_request_n");
		check({31'h0, fast_request_n}, {31'h0, fr}, "fast_request_n");
		check({31'h0, hresp}, 32'h0, "hresp");
		// back on a rising edge so the next bus request starts there
		@(posedge clk);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// read results arrive in issue order, oldest note first
	always @(rd_cnt) begin
		if (rd_cnt !== 8'h0) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("unexpected read_data expected none seen %h", rd_data);
			end else begin
				check(rd_data, exp_q.pop_front(), "read_data");
			end
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// generous bound, the sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end

	initial begin
		arst_n = 1'b0;
		fast_pin = 1'b1;
		system_lines = 4'h0;
		per_lines = {3'b111, 27'h0};
		seed = 32'h2e04;
		fail_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rd(vic_pkg::OFS_CORE, 32'h0);
		rd(vic_pkg::OFS_MASK, 32'h0);
		rd(9'h1fc, 32'h0);
		seed = lfsr(seed);
		wr(vic_pkg::OFS_ENABLE, seed);
		rd(vic_pkg::OFS_MASK, seed);
		wr(vic_pkg::OFS_DISABLE, 32'hffffffff);
		rd(vic_pkg::OFS_MASK, 32'h0);
		// modes and handler addresses of the sources used below
		for (n = 0; n < 7; n++) begin
			wr(vic_pkg::OFS_MODE_BASE + 9'(4 * src_tab[n]), mode_tab[n]);
			wr(vic_pkg::OFS_VEC_BASE + 9'(4 * src_tab[n]),
				32'h0a00 + 32'(src_tab[n]));
		end
		rd(vic_pkg::OFS_MODE_BASE + 9'h24, 32'h06);
		wr(vic_pkg::OFS_ENABLE, 32'h000002a1);
		wr(vic_pkg::OFS_SET, 32'h00000aa0);
		rd(vic_pkg::OFS_PENDING, 32'h000008a0);
		lines(1'b0, 1'b1);
		rd(vic_pkg::OFS_CORE, 32'h1);
		take(1'b0, 32'h0a05);
		lines(1'b1, 1'b1);
		rd(vic_pkg::OFS_CUR_NUM, 32'h5);
		rd(vic_pkg::OFS_PENDING, 32'h00000880);
		per_lines[9] <= 1'b1;
		repeat (3) @(posedge clk);
		lines(1'b0, 1'b1);
		take(1'b0, 32'h0a09);
		rd(vic_pkg::OFS_CUR_NUM, 32'h9);
		per_lines[9] <= 1'b0;
		core.leave_irq();
		rd(vic_pkg::OFS_CUR_NUM, 32'h5);
		lines(1'b1, 1'b1);
		core.leave_irq();
		// the request returns one edge after the pop lands
		@(posedge clk);
		lines(1'b0, 1'b1);
		take(1'b0, 32'h0a07);
		core.leave_irq();
		wr(vic_pkg::OFS_CLEAR, 32'h00000800);
		rd(vic_pkg::OFS_PENDING, 32'h0);
		// falling edge on a pin stays latched after the pin returns
		per_lines[31] <= 1'b0;
		repeat (4) @(posedge clk);
		per_lines[31] <= 1'b1;
		repeat (3) @(posedge clk);
		rd(vic_pkg::OFS_PENDING, 32'h80000000);
		wr(vic_pkg::OFS_CLEAR, 32'h80000000);
		system_lines <= 4'h4;
		repeat (2) @(posedge clk);
		rd(vic_pkg::OFS_PENDING, 32'h00000002);
		system_lines <= 4'h0;
		fast_pin <= 1'b0;
		repeat (4) @(posedge clk);
		fast_pin <= 1'b1;
		repeat (3) @(posedge clk);
		lines(1'b1, 1'b0);
		take(1'b1, 32'h0a00);
		lines(1'b1, 1'b1);
		// a forced source raises only the fast request, bit 0 not forceable
		wr(vic_pkg::OFS_FF_ENABLE, 32'h00000021);
		rd(vic_pkg::OFS_FF_STATUS, 32'h00000020);
		wr(vic_pkg::OFS_SET, 32'h00000020);
		@(posedge clk);
		lines(1'b1, 1'b0);
		take(1'b0, 32'h0);
		rd(vic_pkg::OFS_PENDING, 32'h00000020);
		wr(vic_pkg::OFS_FF_DISABLE, 32'h00000020);
		@(posedge clk);
		lines(1'b0, 1'b1);
		take(1'b0, 32'h0a05);
		core.leave_irq();
		rd(vic_pkg::OFS_PENDING, 32'h0);
		// reset in mid-run drops mask, current number and both requests
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(vic_pkg::OFS_MASK, 32'h0);
		rd(vic_pkg::OFS_CUR_NUM, 32'h0);
		lines(1'b1, 1'b1);
		repeat (4) @(posedge clk);
		results();
	end
endmodule // vic_vectored_irq_ctrl_test
